// >>> logic/tgc_pkg.sv
`default_nettype none
package tgc_pkg;

  // ****************************************
  // Bus widths
  // ****************************************
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [ADDR_W-1:0] OFS_GATE_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_GATE_SEL  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_FLAG  = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 4'h3;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned BIT_GATE_EN   = 7;
  localparam int unsigned BIT_GATE_POL  = 6;
  localparam int unsigned BIT_TOGGLE_EN = 5;
  localparam int unsigned BIT_SPULSE_EN = 4;
  localparam int unsigned BIT_ARM       = 3;
  localparam int unsigned BIT_LEVEL     = 2;
  localparam int unsigned SEL_LSB       = 0;
  localparam int unsigned SEL_W         = 2;
  localparam int unsigned BIT_CMP1_SYNC = 4;
  localparam int unsigned BIT_CMP2_SYNC = 5;
  localparam int unsigned BIT_GATE_FLAG = 0;
  localparam int unsigned BIT_GATE_IEN  = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [DATA_W-1:0] RST_GATE_CTRL = 8'h00;
  localparam logic [DATA_W-1:0] RST_GATE_SEL  = 8'h00;
  localparam logic              RST_BIT       = 1'b0;

  // ****************************************
  // Gate source codes
  // ****************************************
  typedef enum logic [SEL_W-1:0] {
    TGC_SRC_PIN  = 2'b00,
    TGC_SRC_COMP = 2'b01,
    TGC_SRC_CMP1 = 2'b10,
    TGC_SRC_CMP2 = 2'b11
  } tgc_src_t;

endpackage
`default_nettype wire

// >>> logic/tgc_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module tgc_sync2 #(
  parameter int unsigned W = 2
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1_q;

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      stage1_q <= '0;
      q        <= '0;
    end else begin
      stage1_q <= d;
      q        <= stage1_q;
    end
  end

endmodule
`default_nettype wire

// >>> logic/tgc_gate_shaper.sv
`timescale 1ns/100ps
`default_nettype none
module tgc_gate_shaper (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic gate_in,
  input  wire logic toggle_en,
  input  wire logic spulse_en,
  input  wire logic arm,
  output logic      level_d,
  output logic      arm_clear,
  output logic      window_open
);

  logic in_prev_q;
  logic tog_q;
  logic shaped;
  logic shaped_prev_q;
  logic open_q;
  logic in_rise;
  logic sh_rise;
  logic sh_fall;

  assign in_rise = gate_in & ~in_prev_q;
  assign shaped  = toggle_en ? tog_q : gate_in;
  assign sh_rise = shaped & ~shaped_prev_q;
  assign sh_fall = ~shaped & shaped_prev_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      in_prev_q     <= 1'b0;
      shaped_prev_q <= 1'b0;
    end else begin
      in_prev_q     <= gate_in;
      shaped_prev_q <= shaped;
    end
  end

  // ****************************************
  // Toggle flip-flop
  // ****************************************
  // toggle or hold clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tog_q <= 1'b0;
    end else if (!toggle_en) begin
      tog_q <= 1'b0;
    end else if (in_rise) begin
      tog_q <= ~tog_q;
    end
  end

  // ****************************************
  // Single-pulse window
  // ****************************************
  // open only when armed
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      open_q <= 1'b0;
    end else if (!spulse_en) begin
      open_q <= 1'b0;
    end else if (!open_q && arm && sh_rise) begin
      open_q <= 1'b1;
    end else if (open_q && sh_fall) begin
      open_q <= 1'b0;
    end
  end

  assign arm_clear   = spulse_en & open_q & sh_fall;
  assign level_d     = spulse_en ? (open_q & shaped) : shaped;
  assign window_open = open_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_tog_held;
    @(posedge clock) disable iff (!rstn)
      !toggle_en |=> !tog_q;
  endproperty
  a_tog_held: assert property (p_tog_held) else $error("toggle ff not held clear");

  property p_tog_flip;
    @(posedge clock) disable iff (!rstn)
      (toggle_en && gate_in && !in_prev_q) ##1 toggle_en |-> tog_q != $past(tog_q);
  endproperty
  a_tog_flip: assert property (p_tog_flip) else $error("toggle ff missed an edge");

  property p_open_needs_arm;
    @(posedge clock) disable iff (!rstn)
      !arm |=> !$rose(open_q);
  endproperty
  a_open_needs_arm: assert property (p_open_needs_arm) else $error("window opened unarmed");

endmodule
`default_nettype wire

// >>> logic/tgc_timer_gate_control.sv
`timescale 1ns/100ps
`default_nettype none
module tgc_timer_gate_control (
  input  wire logic                       clock,
  input  wire logic                       rstn,
  input  wire logic [tgc_pkg::ADDR_W-1:0] addr,
  input  wire logic [tgc_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output logic      [tgc_pkg::DATA_W-1:0] rdata,
  input  wire logic                       gate_input_pin,
  input  wire logic                       companion_overflow,
  input  wire logic                       companion_period_match,
  input  wire logic                       companion_8bit_mode,
  input  wire logic                       first_comparator_out,
  input  wire logic                       second_comparator_out,
  output logic                            count_enable,
  output logic                            gate_level_status,
  output logic                            irq
);

  // ****************************************
  // Declarations
  // ****************************************
  logic                       gate_enable_q;
  logic                       gate_polarity_q;
  logic                       gate_toggle_enable_q;
  logic                       gate_single_pulse_enable_q;
  logic                       gate_pulse_arm_q;
  tgc_pkg::tgc_src_t          gate_source_select_q;
  logic                       cmp1_sync_en_q;
  logic                       cmp2_sync_en_q;
  logic                       gate_event_flag_q;
  logic                       gate_event_irq_enable_q;
  logic                       gate_level_q;
  logic [tgc_pkg::DATA_W-1:0] rdata_q;
  logic [tgc_pkg::DATA_W-1:0] rdata_d;
  logic [1:0]                 cmp_sync;
  logic                       cmp1_sel;
  logic                       cmp2_sel;
  logic                       companion_pulse;
  logic                       src_raw;
  logic                       src_pol;
  logic                       level_d;
  logic                       arm_clear;
  logic                       window_open;
  logic                       wr_ctrl;
  logic                       wr_sel;
  logic                       wr_flag;
  logic                       wr_ien;
  logic                       gate_fall;

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    wr_ctrl = 1'b0;
    wr_sel  = 1'b0;
    wr_flag = 1'b0;
    wr_ien  = 1'b0;
    if (wr_stb && addr == tgc_pkg::OFS_GATE_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (wr_stb && addr == tgc_pkg::OFS_GATE_SEL) begin
      wr_sel = 1'b1;
    end else if (wr_stb && addr == tgc_pkg::OFS_IRQ_FLAG) begin
      wr_flag = 1'b1;
    end else if (wr_stb && addr == tgc_pkg::OFS_IRQ_EN) begin
      wr_ien = 1'b1;
    end
  end

  // ****************************************
  // Gate control register
  // ****************************************
  // mode bits from software
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_enable_q              <= tgc_pkg::RST_GATE_CTRL[tgc_pkg::BIT_GATE_EN];
      gate_polarity_q            <= tgc_pkg::RST_GATE_CTRL[tgc_pkg::BIT_GATE_POL];
      gate_toggle_enable_q       <= tgc_pkg::RST_GATE_CTRL[tgc_pkg::BIT_TOGGLE_EN];
      gate_single_pulse_enable_q <= tgc_pkg::RST_GATE_CTRL[tgc_pkg::BIT_SPULSE_EN];
    end else if (wr_ctrl) begin
      gate_enable_q              <= wdata[tgc_pkg::BIT_GATE_EN];
      gate_polarity_q            <= wdata[tgc_pkg::BIT_GATE_POL];
      gate_toggle_enable_q       <= wdata[tgc_pkg::BIT_TOGGLE_EN];
      gate_single_pulse_enable_q <= wdata[tgc_pkg::BIT_SPULSE_EN];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_pulse_arm_q <= tgc_pkg::RST_GATE_CTRL[tgc_pkg::BIT_ARM];
    end else if (wr_ctrl) begin
      gate_pulse_arm_q <= wdata[tgc_pkg::BIT_ARM];
    end else if (arm_clear) begin
      gate_pulse_arm_q <= 1'b0;
    end
  end

  // ****************************************
  // Gate select register
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_source_select_q <= tgc_pkg::tgc_src_t'(
        tgc_pkg::RST_GATE_SEL[tgc_pkg::SEL_LSB +: tgc_pkg::SEL_W]);
      cmp1_sync_en_q       <= tgc_pkg::RST_GATE_SEL[tgc_pkg::BIT_CMP1_SYNC];
      cmp2_sync_en_q       <= tgc_pkg::RST_GATE_SEL[tgc_pkg::BIT_CMP2_SYNC];
    end else if (wr_sel) begin
      gate_source_select_q <= tgc_pkg::tgc_src_t'(wdata[tgc_pkg::SEL_LSB +: tgc_pkg::SEL_W]);
      cmp1_sync_en_q       <= wdata[tgc_pkg::BIT_CMP1_SYNC];
      cmp2_sync_en_q       <= wdata[tgc_pkg::BIT_CMP2_SYNC];
    end
  end

  // ****************************************
  // Gate sources
  // ****************************************
  tgc_sync2 #(
    .W (2)
  ) u_cmp_sync (
    .clock (clock),
    .rstn  (rstn),
    .d     ({second_comparator_out, first_comparator_out}),
    .q     (cmp_sync)
  );

  assign cmp1_sel = cmp1_sync_en_q ? cmp_sync[0] : first_comparator_out;
  assign cmp2_sel = cmp2_sync_en_q ? cmp_sync[1] : second_comparator_out;

  assign companion_pulse = companion_overflow | (companion_period_match & companion_8bit_mode);

  always_comb begin
    case (gate_source_select_q)
      tgc_pkg::TGC_SRC_PIN:  src_raw = gate_input_pin;
      tgc_pkg::TGC_SRC_COMP: src_raw = companion_pulse;
      tgc_pkg::TGC_SRC_CMP1: src_raw = cmp1_sel;
      tgc_pkg::TGC_SRC_CMP2: src_raw = cmp2_sel;
      default:               src_raw = 1'b0;
    endcase
  end

  assign src_pol = src_raw ^ gate_polarity_q;

  // ****************************************
  // Toggle and single-pulse shaping
  // ****************************************
  tgc_gate_shaper u_shaper (
    .clock       (clock),
    .rstn        (rstn),
    .gate_in     (src_pol),
    .toggle_en   (gate_toggle_enable_q),
    .spulse_en   (gate_single_pulse_enable_q),
    .arm         (gate_pulse_arm_q),
    .level_d     (level_d),
    .arm_clear   (arm_clear),
    .window_open (window_open)
  );

  // ****************************************
  // Gate level and count qualifier
  // ****************************************
  // level runs regardless of gate enable
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_level_q <= 1'b0;
    end else begin
      gate_level_q <= level_d;
    end
  end

  assign count_enable      = ~gate_enable_q | gate_level_q;
  assign gate_level_status = gate_level_q;

  // ****************************************
  // Gate event flag and interrupt
  // ****************************************
  assign gate_fall = ~level_d & gate_level_q;

  // set on falling level, set wins
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_event_flag_q <= 1'b0;
    end else if (gate_fall) begin
      gate_event_flag_q <= 1'b1;
    end else if (wr_flag) begin
      gate_event_flag_q <= wdata[tgc_pkg::BIT_GATE_FLAG];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_event_irq_enable_q <= 1'b0;
    end else if (wr_ien) begin
      gate_event_irq_enable_q <= wdata[tgc_pkg::BIT_GATE_IEN];
    end
  end

  assign irq = gate_event_flag_q & gate_event_irq_enable_q;

  // ****************************************
  // Read path
  // ****************************************
  // arm and level visible
  always_comb begin
    rdata_d = '0;
    if (rd_stb && addr == tgc_pkg::OFS_GATE_CTRL) begin
      rdata_d[tgc_pkg::BIT_GATE_EN]   = gate_enable_q;
      rdata_d[tgc_pkg::BIT_GATE_POL]  = gate_polarity_q;
      rdata_d[tgc_pkg::BIT_TOGGLE_EN] = gate_toggle_enable_q;
      rdata_d[tgc_pkg::BIT_SPULSE_EN] = gate_single_pulse_enable_q;
      rdata_d[tgc_pkg::BIT_ARM]       = gate_pulse_arm_q;
      rdata_d[tgc_pkg::BIT_LEVEL]     = gate_level_q;
    end else if (rd_stb && addr == tgc_pkg::OFS_GATE_SEL) begin
      rdata_d[tgc_pkg::SEL_LSB +: tgc_pkg::SEL_W] = gate_source_select_q;
      rdata_d[tgc_pkg::BIT_CMP1_SYNC]             = cmp1_sync_en_q;
      rdata_d[tgc_pkg::BIT_CMP2_SYNC]             = cmp2_sync_en_q;
    end else if (rd_stb && addr == tgc_pkg::OFS_IRQ_FLAG) begin
      rdata_d[tgc_pkg::BIT_GATE_FLAG] = gate_event_flag_q;
    end else if (rd_stb && addr == tgc_pkg::OFS_IRQ_EN) begin
      rdata_d[tgc_pkg::BIT_GATE_IEN] = gate_event_irq_enable_q;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_gate_blocks;
    gate_enable_q && !wr_ctrl && !level_d |=> !count_enable;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("count while gate closed");

  property p_ungated_counts;
    !(wr_ctrl ? wdata[tgc_pkg::BIT_GATE_EN] : gate_enable_q) |=> count_enable;
  endproperty
  a_ungated_counts: assert property (p_ungated_counts) else $error("ungated timer stalled");

  property p_pin_polarity;
    (gate_source_select_q == tgc_pkg::TGC_SRC_PIN && !gate_toggle_enable_q
      && !gate_single_pulse_enable_q)
      |=> gate_level_q == $past(gate_input_pin ^ gate_polarity_q);
  endproperty
  a_pin_polarity: assert property (p_pin_polarity) else $error("pin level wrong");

  property p_companion_pulse;
    (gate_source_select_q == tgc_pkg::TGC_SRC_COMP && !gate_toggle_enable_q
      && !gate_single_pulse_enable_q && !gate_polarity_q && companion_period_match
      && companion_8bit_mode) |=> gate_level_q;
  endproperty
  a_companion_pulse: assert property (p_companion_pulse) else $error("companion pulse lost");

  property p_cmp1_async;
    (gate_source_select_q == tgc_pkg::TGC_SRC_CMP1 && !cmp1_sync_en_q
      && !gate_toggle_enable_q && !gate_single_pulse_enable_q && !gate_polarity_q)
      |=> gate_level_q == $past(first_comparator_out);
  endproperty
  a_cmp1_async: assert property (p_cmp1_async) else $error("comparator one path wrong");

  property p_cmp2_sync;
    (gate_source_select_q == tgc_pkg::TGC_SRC_CMP2 && cmp2_sync_en_q
      && !gate_toggle_enable_q && !gate_single_pulse_enable_q && !gate_polarity_q)[*3]
      |=> gate_level_q == $past(second_comparator_out, 3);
  endproperty
  a_cmp2_sync: assert property (p_cmp2_sync) else $error("comparator two sync wrong");

  property p_arm_done;
    arm_clear && !wr_ctrl |=> !gate_pulse_arm_q;
  endproperty
  a_arm_done: assert property (p_arm_done) else $error("arm not cleared at trailing edge");

  property p_flag_on_fall;
    $fell(gate_level_q) |-> gate_event_flag_q;
  endproperty
  a_flag_on_fall: assert property (p_flag_on_fall) else $error("falling level missed flag");

  property p_irq;
    gate_fall && gate_event_irq_enable_q && !wr_ien |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_level_read;
    rd_stb && addr == tgc_pkg::OFS_GATE_CTRL
      |=> rdata[tgc_pkg::BIT_LEVEL] == $past(gate_level_q)
          && rdata[tgc_pkg::BIT_ARM] == $past(gate_pulse_arm_q);
  endproperty
  a_level_read: assert property (p_level_read) else $error("status read wrong");

  property p_cov_fall;
    $fell(gate_level_q) && !gate_enable_q;
  endproperty
  c_cov_fall: cover property (p_cov_fall);

  property p_cov_single;
    gate_single_pulse_enable_q && arm_clear;
  endproperty
  c_cov_single: cover property (p_cov_single);

  property p_cov_both;
    gate_single_pulse_enable_q && gate_toggle_enable_q && window_open ##1 arm_clear;
  endproperty
  c_cov_both: cover property (p_cov_both);

endmodule
`default_nettype wire

// >>> tb/tgc_src_model.sv
`timescale 1ns/100ps
`default_nettype none
module tgc_src_model (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [5:0] req,
  output logic      [5:0] src_q
);
  // ****************************************
  // Gate sources
  // ****************************************
  // Bits: pin, overflow, match, 8-bit mode, comparator one, comparator two
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      src_q <= 6'h00;
    end else begin
      src_q <= req;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tgc_timer_gate_control_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tgc_timer_gate_control_tb_top;
  localparam logic [7:0] GE  = 8'h01 << tgc_pkg::BIT_GATE_EN;
  localparam logic [7:0] POL = 8'h01 << tgc_pkg::BIT_GATE_POL;
  localparam logic [7:0] TOG = 8'h01 << tgc_pkg::BIT_TOGGLE_EN;
  localparam logic [7:0] SP  = 8'h01 << tgc_pkg::BIT_SPULSE_EN;
  localparam logic [7:0] ARM = 8'h01 << tgc_pkg::BIT_ARM;
  localparam logic [7:0] LVL = 8'h01 << tgc_pkg::BIT_LEVEL;
  logic       clock;
  logic       rstn;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] rdata;
  logic [5:0] req;
  logic [5:0] src_q;
  logic       count_enable;
  logic       gate_level_status;
  logic       irq;
  int         n_mismatch;
  int         n_tests;
  int         cyc;

  tgc_src_model u_src (.clock(clock), .rstn(rstn), .req(req), .src_q(src_q));
  tgc_timer_gate_control dut (
    .clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .gate_input_pin(src_q[0]),
    .companion_overflow(src_q[1]), .companion_period_match(src_q[2]),
    .companion_8bit_mode(src_q[3]), .first_comparator_out(src_q[4]),
    .second_comparator_out(src_q[5]), .count_enable(count_enable),
    .gate_level_status(gate_level_status), .irq(irq)
  );

  always #2.5 clock = ~clock;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask

  task automatic drv(input int i, input logic v);
    @(posedge clock);
    req[i] <= v;
  endtask

  // Settle, then compare level and count qualifier
  task automatic lvl(input logic e, input logic ce);
    repeat (6) @(posedge clock);
    #1;
    chk("gate_level_status", {7'h00, gate_level_status}, {7'h00, e});
    chk("count_enable", {7'h00, count_enable}, {7'h00, ce});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("count_enable", {7'h00, count_enable}, 8'h01);
    chk("irq", {7'h00, irq}, 8'h00);
    for (int a = 0; a < 5; a++) begin
      rd_chk((a == 4) ? 4'hF : a[3:0], 8'h00);
    end
  endtask

  task automatic t_sources;
    int i;
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        for (int y = 0; y < 2; y++) begin
          if (s != 1) begin
            i = (s == 0) ? 0 : ((s == 2) ? 4 : 5);
            // Sync enables at b5:b4, source code at b1:b0
            wr(4'h1, {2'b00, y[0], y[0], 2'b00, s[1:0]});
            wr(4'h0, GE | (p[0] ? POL : 8'h00));
            drv(i, 1'b0);
            lvl(p[0], p[0]);
            drv(i, 1'b1);
            lvl(~p[0], ~p[0]);
            rd_chk(4'h0, GE | (p[0] ? POL : LVL));
            drv(i, 1'b0);
          end
        end
      end
    end
  endtask

  task automatic t_ungated;
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h00);
    drv(0, 1'b1);
    lvl(1'b1, 1'b1);
    // Clear flag left by polarity change, then make one fall
    wr(4'h2, 8'h00);
    rd_chk(4'h2, 8'h00);
    drv(0, 1'b0);
    lvl(1'b0, 1'b1);
    rd_chk(4'h2, 8'h01);
    chk("irq", {7'h00, irq}, 8'h01);
    wr(4'h3, 8'h00);
    @(posedge clock);
    #1;
    chk("irq", {7'h00, irq}, 8'h00);
    wr(4'h2, 8'h00);
    rd_chk(4'h2, 8'h00);
  endtask

  task automatic t_toggle;
    // Polarity kept fixed while toggling is switched
    wr(4'h0, GE | TOG);
    drv(0, 1'b1);
    lvl(1'b1, 1'b1);
    drv(0, 1'b0);
    lvl(1'b1, 1'b1);
    drv(0, 1'b1);
    lvl(1'b0, 1'b0);
    wr(4'h0, GE);
    lvl(1'b1, 1'b1);
    wr(4'h0, GE | TOG);
    lvl(1'b0, 1'b0);
    drv(0, 1'b0);
  endtask

  task automatic t_companion;
    wr(4'h1, 8'h01);
    wr(4'h0, GE | TOG);
    drv(1, 1'b1);
    drv(1, 1'b0);
    lvl(1'b1, 1'b1);
    drv(2, 1'b1);
    drv(2, 1'b0);
    lvl(1'b1, 1'b1);
    drv(3, 1'b1);
    drv(2, 1'b1);
    drv(2, 1'b0);
    lvl(1'b0, 1'b0);
    drv(3, 1'b0);
    wr(4'h1, 8'h00);
  endtask

  task automatic t_single;
    wr(4'h2, 8'h00);
    wr(4'h0, GE | SP);
    wr(4'h0, GE | SP | ARM);
    rd_chk(4'h0, GE | SP | ARM);
    drv(0, 1'b1);
    lvl(1'b1, 1'b1);
    drv(0, 1'b0);
    lvl(1'b0, 1'b0);
    rd_chk(4'h0, GE | SP);
    rd_chk(4'h2, 8'h01);
    drv(0, 1'b1);
    lvl(1'b0, 1'b0);
    drv(0, 1'b0);
    // Leave single pulse with arm cleared too
    wr(4'h0, GE);
    wr(4'h2, 8'h00);
  endtask

  task automatic t_both;
    wr(4'h0, GE | TOG | SP);
    wr(4'h0, GE | TOG | SP | ARM);
    drv(0, 1'b1);
    lvl(1'b1, 1'b1);
    drv(0, 1'b0);
    lvl(1'b1, 1'b1);
    drv(0, 1'b1);
    lvl(1'b0, 1'b0);
    rd_chk(4'h0, GE | TOG | SP);
    drv(0, 1'b0);
  endtask

  // ****************************************
  // Watchdog and main sequence
  // ****************************************
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  initial begin
    clock      = 1'b0;
    rstn       = 1'b0;
    addr       = 4'h0;
    wdata      = 8'h00;
    wr_stb     = 1'b0;
    rd_stb     = 1'b0;
    req        = 6'h00;
    n_mismatch = 0;
    n_tests    = 0;
    cyc        = 0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_reset;
    t_sources;
    t_ungated;
    t_toggle;
    t_companion;
    t_single;
    t_both;
    tally_and_finish;
  end
endmodule
`default_nettype wire
